// ==== shared/otprs_pkg.sv ====
package otprs_pkg;

    // ------------------------------------------------------------
    // Clock and times
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // Anti-fuse power-up settle time, least
    localparam int SETTLE_NS     = 1000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Software reset completes within this time, longest
    localparam int SWRST_NS      = 200;
    localparam int SWRST_CYC     = SWRST_NS / CLK_PERIOD_NS;
    // Burn time, least
    localparam int BURN_MS       = 50;
    localparam int BURN_CYC      = (BURN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 21;
    localparam int SCAN_DIV_DEF  = 2;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_BRIGHT_A   = 8'h01;
    localparam logic [7:0] CMD_BRIGHT_B   = 8'h02;
    localparam logic [7:0] CMD_BOOST      = 8'h03;
    localparam logic [7:0] CMD_DISPLAY    = 8'h10;
    localparam logic [7:0] CMD_SLEEP      = 8'hF1;
    localparam logic [7:0] CMD_SW_RESET   = 8'hF2;
    localparam logic [7:0] CMD_GROUND_TIE = 8'hF3;
    localparam logic [7:0] CMD_OTP_BURN   = 8'hF5;
    localparam logic [7:0] CMD_PROGRAMMED_FLAG_CHECK = 8'hF7;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] GROUND_TIE_RST = 8'h01;
    localparam logic [6:0] BRIGHT_RST     = 7'h00;
    localparam logic [7:0] PEND_RST       = 8'h00;
    localparam int         ENABLE_BIT     = 0;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'b000,
        ST_PWRUP = 3'b001,
        ST_READ  = 3'b010,
        ST_PWRDN = 3'b011,
        ST_RUN   = 3'b100,
        ST_BURN  = 3'b101
    } otprs_state_e;

    // Latch array contents, mirrored in the anti-fuse array
    typedef struct packed {
        logic [6:0] bright_b;
        logic [6:0] bright_a;
    } otprs_cfg_s;

    // One byte from the command bus front end
    typedef struct packed {
        logic       valid;
        logic       is_code;
        logic [7:0] value;
    } otprs_cmd_s;

endpackage : otprs_pkg

// ==== hw/otprs_ctrl.sv ====
`timescale 1ns/1ps
module otprs_ctrl
    import otprs_pkg::*;
#(
    parameter int BURN_CYCLES = BURN_CYC,
    parameter int SCAN_DIV    = SCAN_DIV_DEF
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       rst_pad_n,
    // Command bytes from the bus front end
    input  wire otprs_cmd_s cmd,
    // Anti-fuse array
    input  wire otprs_cfg_s antifuse_rd_data,
    input  wire logic       programmed_flag,
    output logic            antifuse_pwr_on,
    output logic            antifuse_rd_en,
    output logic            antifuse_burn_en,
    output otprs_cfg_s      antifuse_wr_data,
    // Configuration to the rest of the chip
    output otprs_cfg_s      latch_array,
    output logic            core_rst,
    // Power and drive state
    output logic            osc_en,
    output logic            conv_en,
    output logic            analog_en,
    output logic            driver_release,
    output logic            sync_release,
    output logic            scan_clock_out,
    output logic            ground_tie_enable,
    output logic            sleep_active,
    output logic            burn_busy
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic code_is(input otprs_cmd_s c, input logic [7:0] code);
        code_is = c.valid && c.is_code && (c.value == code);
    endfunction : code_is

    function automatic logic [CNT_W-1:0] cycles(input int n);
        cycles = CNT_W'(n - 1);
    endfunction : cycles

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic             pad_meta_r;
    logic             pad_sync_r;
    logic             pad_low;
    otprs_state_e     state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [7:0]       pend_r;
    logic             data_valid;
    logic             running;
    logic             sw_reset;
    logic             burn_start;
    logic             boost_on_r;
    logic             disp_on_r;
    logic             sleep_r;
    logic             tie_r;
    otprs_cfg_s       latch_r;
    logic [7:0]       div_cnt_r;
    logic             scan_r;

    // ------------------------------------------------------------
    // Reset pad synchroniser
    // ------------------------------------------------------------
    // Pad is asynchronous to clk; only the second flop is read
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pad_meta_r <= 1'b0;
            pad_sync_r <= 1'b0;
        end
        else
        begin
            pad_meta_r <= rst_pad_n;
            pad_sync_r <= pad_meta_r;
        end
    end

    assign pad_low = !pad_sync_r;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Commands are only acted on once the latches are valid; a burn in
    // flight ignores everything, which keeps the anti-fuse write stable
    assign running    = (state_r == ST_RUN);
    assign data_valid = running && cmd.valid && !cmd.is_code;
    // A lone code byte resets; programmed_flag check resets only when programmed
    assign sw_reset   = running && (code_is(cmd, CMD_SW_RESET)
                      || (code_is(cmd, CMD_PROGRAMMED_FLAG_CHECK) && programmed_flag));
    assign burn_start = data_valid && (pend_r == CMD_OTP_BURN)
                      && cmd.value[ENABLE_BIT];

    // Last code byte seen, steering the data byte that follows
    always_ff @(posedge clk)
    begin
        if (rst || pad_low || state_r == ST_HOLD)
            pend_r <= PEND_RST;
        else if (running && cmd.valid && cmd.is_code)
            pend_r <= cmd.value;
    end

    // ------------------------------------------------------------
    // Reset, load and burn sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || pad_low)
        begin
            state_r <= ST_HOLD;
            cnt_r   <= cycles(SWRST_CYC);
        end
        else
        begin
            unique case (state_r)
                ST_HOLD:
                begin
                    // Reset completes after SWRST_CYC cycles, inside 200 ns
                    if (cnt_r == '0)
                    begin
                        state_r <= ST_PWRUP;
                        cnt_r   <= cycles(SETTLE_CYC);
                    end
                    else
                        cnt_r <= cnt_r - CNT_W'(1);
                end
                ST_PWRUP:
                begin
                    if (cnt_r == '0)
                        state_r <= ST_READ;
                    else
                        cnt_r <= cnt_r - CNT_W'(1);
                end
                ST_READ:  state_r <= ST_PWRDN;
                ST_PWRDN: state_r <= ST_RUN;
                ST_RUN:
                begin
                    if (sw_reset)
                    begin
                        state_r <= ST_HOLD;
                        cnt_r   <= cycles(SWRST_CYC);
                    end
                    else if (burn_start)
                    begin
                        state_r <= ST_BURN;
                        cnt_r   <= cycles(BURN_CYCLES);
                    end
                end
                ST_BURN:
                begin
                    // Ends by itself; no command can cut it short
                    if (cnt_r == '0)
                        state_r <= ST_RUN;
                    else
                        cnt_r <= cnt_r - CNT_W'(1);
                end
                default:
                    state_r <= ST_HOLD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Latch array
    // ------------------------------------------------------------
    // Brightness writes land here; the read state overwrites with fuses
    always_ff @(posedge clk)
    begin
        if (rst || pad_low)
        begin
            latch_r.bright_a <= BRIGHT_RST;
            latch_r.bright_b <= BRIGHT_RST;
        end
        else if (state_r == ST_READ)
            latch_r <= antifuse_rd_data;
        else if (data_valid && pend_r == CMD_BRIGHT_A)
            latch_r.bright_a <= cmd.value[6:0];
        else if (data_valid && pend_r == CMD_BRIGHT_B)
            latch_r.bright_b <= cmd.value[6:0];
    end

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    // Ground tie is closed by default so a stray supply cannot burn fuses
    always_ff @(posedge clk)
    begin
        if (rst || pad_low || state_r == ST_HOLD)
            tie_r <= GROUND_TIE_RST[ENABLE_BIT];
        else if (data_valid && pend_r == CMD_GROUND_TIE)
            tie_r <= cmd.value[ENABLE_BIT];
    end

    // Converter and display enables; both default off
    always_ff @(posedge clk)
    begin
        if (rst || pad_low || state_r == ST_HOLD)
        begin
            boost_on_r <= 1'b0;
            disp_on_r  <= 1'b0;
        end
        else if (data_valid && pend_r == CMD_BOOST)
            boost_on_r <= cmd.value[ENABLE_BIT];
        else if (data_valid && pend_r == CMD_DISPLAY)
            disp_on_r <= cmd.value[ENABLE_BIT];
    end

    // Sleep: set by its code, cleared by the converter or display code
    always_ff @(posedge clk)
    begin
        if (rst || pad_low || state_r == ST_HOLD)
            sleep_r <= 1'b0;
        else if (running && (code_is(cmd, CMD_BOOST) || code_is(cmd, CMD_DISPLAY)))
            sleep_r <= 1'b0;
        else if (running && code_is(cmd, CMD_SLEEP))
            sleep_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Scan clock divider
    // ------------------------------------------------------------
    // Runs only once configuration is valid, so no early edges escape
    always_ff @(posedge clk)
    begin
        if (rst || pad_low || !(running || state_r == ST_BURN))
        begin
            div_cnt_r <= 8'h00;
            scan_r    <= 1'b0;
        end
        else if (div_cnt_r == 8'(SCAN_DIV - 1))
        begin
            div_cnt_r <= 8'h00;
            scan_r    <= !scan_r;
        end
        else
            div_cnt_r <= div_cnt_r + 8'h01;
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || pad_low)
        begin
            osc_en            <= 1'b0;
            core_rst          <= 1'b1;
            conv_en           <= 1'b0;
            analog_en         <= 1'b0;
            driver_release    <= 1'b0;
            sync_release      <= 1'b0;
            scan_clock_out    <= 1'b0;
            ground_tie_enable <= GROUND_TIE_RST[ENABLE_BIT];
            sleep_active      <= 1'b0;
            burn_busy         <= 1'b0;
            antifuse_pwr_on   <= 1'b0;
            antifuse_rd_en    <= 1'b0;
            antifuse_burn_en  <= 1'b0;
            antifuse_wr_data  <= '0;
            latch_array       <= '0;
        end
        else
        begin
            // Oscillator and bus keep running through sleep
            osc_en            <= 1'b1;
            core_rst          <= !(running || state_r == ST_BURN);
            conv_en           <= running && boost_on_r && !sleep_r;
            analog_en         <= running && !sleep_r;
            driver_release    <= running && disp_on_r && !sleep_r;
            // Sync release follows the driver release: high only while running with display on and not asleep
            sync_release      <= running && disp_on_r && !sleep_r;
            scan_clock_out    <= scan_r;
            ground_tie_enable <= tie_r;
            sleep_active      <= sleep_r;
            burn_busy         <= (state_r == ST_BURN);
            antifuse_pwr_on   <= (state_r == ST_PWRUP) || (state_r == ST_READ)
                               || (state_r == ST_BURN);
            antifuse_rd_en    <= (state_r == ST_PWRUP) && (cnt_r == '0);
            antifuse_burn_en  <= (state_r == ST_BURN);
            antifuse_wr_data  <= latch_r;
            latch_array       <= latch_r;
        end
    end

endmodule : otprs_ctrl

// ==== testbench/otprs_ctrl_sva.sv ====
`timescale 1ns/1ps
module otprs_ctrl_sva
    import otprs_pkg::*;
#(
    parameter int BURN_CYCLES = BURN_CYC
)(
    // Clock, reset and command bytes
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       rst_pad_n,
    input wire otprs_cmd_s cmd,
    input wire logic       programmed_flag,
    // Watched outputs
    input wire logic       antifuse_pwr_on,
    input wire logic       antifuse_rd_en,
    input wire logic       antifuse_burn_en,
    input wire logic       core_rst,
    input wire logic       osc_en,
    input wire logic       conv_en,
    input wire logic       analog_en,
    input wire logic       driver_release,
    input wire logic       ground_tie_enable,
    input wire logic       sleep_active,
    input wire logic       burn_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Burn length counted in logic, the parameter is too large to unroll
    logic [31:0] burn_cnt_r;
    always_ff @(posedge clk)
    begin
        if (rst || !burn_busy)
            burn_cnt_r <= 32'h0;
        else
            burn_cnt_r <= burn_cnt_r + 32'h1;
    end
    // Byte is taken only when the block still runs one cycle later
    sequence s_code(logic [7:0] c);
        cmd.valid && cmd.is_code && cmd.value == c && !core_rst && !burn_busy
        ##1 !core_rst && !burn_busy;
    endsequence
    sequence s_data;
        cmd.valid && !cmd.is_code;
    endsequence
    a_sleep_enter: assert property (s_code(CMD_SLEEP) |-> ##1 sleep_active)
        else $error("sleep not entered");
    a_wake_up: assert property ((s_code(CMD_BOOST) or s_code(CMD_DISPLAY))
        |-> ##1 !sleep_active) else $error("sleep not left");
    a_sleep_quiet: assert property (sleep_active && !core_rst
        |-> osc_en && !conv_en && !analog_en && !driver_release) else $error("sleep not quiet");
    a_swrst_fast: assert property (s_code(CMD_SW_RESET)
        |-> ##[0:4] (core_rst && ground_tie_enable && osc_en)) else $error("soft reset slow");
    a_tie_follow: assert property (s_code(CMD_GROUND_TIE) ##0 s_data
        |-> ##2 ground_tie_enable == $past(cmd.value[ENABLE_BIT], 2)) else $error("tie wrong");
    a_burn_start: assert property (s_code(CMD_OTP_BURN) ##0 s_data ##0 cmd.value[0]
        |-> ##2 (burn_busy && antifuse_burn_en && antifuse_pwr_on)) else $error("no burn");
    a_burn_len: assert property ($fell(burn_busy)
        |-> burn_cnt_r >= BURN_CYCLES - 1 && burn_cnt_r <= BURN_CYCLES + 1)
        else $error("burn length wrong");
    a_load_order: assert property (antifuse_rd_en
        |-> antifuse_pwr_on && core_rst ##[1:3] !antifuse_pwr_on) else $error("load order");
    a_programmed_flag_reset: assert property (s_code(CMD_PROGRAMMED_FLAG_CHECK) ##0 $past(programmed_flag)
        |-> ##[0:4] core_rst) else $error("programmed_flag check did not reset");
    a_pad_stops: assert property ($fell(rst_pad_n)
        |-> ##[1:4] (!osc_en && core_rst && !conv_en && !driver_release))
        else $error("pad reset ignored");
endmodule : otprs_ctrl_sva

// ==== testbench/otprs_fuse_model.sv ====
`timescale 1ns/1ps
module otprs_fuse_model
    import otprs_pkg::*;
#(
    parameter otprs_cfg_s INIT = 14'h1A5B
)(
    // Clock and array controls
    input wire logic       clk,
    input wire logic       pwr_on,
    input wire logic       burn_en,
    input wire otprs_cfg_s wr_data,
    // Stored contents and programmed_flag flag
    output otprs_cfg_s     rd_data,
    output logic           sealed
);
    otprs_cfg_s store_r = INIT;
    logic       burn_d_r = 1'b0;
    logic       sealed_r = 1'b0;
    // Cells take the burn data; programmed_flag set once burn_en falls, however the burn ends
    always @(posedge clk)
    begin
        burn_d_r <= burn_en;
        if (burn_en)
            store_r <= wr_data;
        if (burn_d_r && !burn_en)
            sealed_r <= 1'b1;
    end
    // One driver for the flag, starting unsealed
    assign sealed = sealed_r;
    // Unpowered array shows garbage, never the stored value
    assign rd_data = pwr_on ? store_r : ~store_r;
endmodule : otprs_fuse_model

// ==== testbench/otp_reset_sleep_control_tb_top.sv ====
`timescale 1ns/1ps
module otp_reset_sleep_control_tb_top;
    import otprs_pkg::*;
    localparam int BURN_N = 20;
    localparam otprs_cfg_s INIT = 14'h1A5B;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rst_pad_n = 1'b1;
    otprs_cmd_s cmd = '0;
    otprs_cfg_s antifuse_rd_data, antifuse_wr_data, latch_array;
    logic programmed_flag, antifuse_pwr_on, antifuse_rd_en, antifuse_burn_en;
    logic core_rst, osc_en, conv_en, analog_en, driver_release, sync_release;
    logic scan_clock_out, ground_tie_enable, sleep_active, burn_busy;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    integer seed = 34764;
    always #20 clk = ~clk;
    otprs_ctrl #(.BURN_CYCLES(BURN_N), .SCAN_DIV(SCAN_DIV_DEF)) DUT (.clk, .rst, .rst_pad_n,
        .cmd, .antifuse_rd_data, .programmed_flag, .antifuse_pwr_on, .antifuse_rd_en,
        .antifuse_burn_en, .antifuse_wr_data, .latch_array, .core_rst, .osc_en, .conv_en,
        .analog_en, .driver_release, .sync_release, .scan_clock_out, .ground_tie_enable,
        .sleep_active, .burn_busy);
    otprs_fuse_model #(.INIT(INIT)) u_fuse (.clk, .pwr_on(antifuse_pwr_on),
        .burn_en(antifuse_burn_en), .wr_data(antifuse_wr_data), .rd_data(antifuse_rd_data),
        .sealed(programmed_flag));
    // ------------------------------------------------------------
    // Checking and host-side bus tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] cfg_of(input logic [6:0] a, input logic [6:0] b);
        return {2'b00, b, a};
    endfunction : cfg_of
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic send(input logic code, input logic [7:0] v);
        @(posedge clk);
        cmd <= '{1'b1, code, v};
    endtask : send
    // Released bus shows the inverse byte, not the last one
    task automatic cmd1(input logic [7:0] c, input logic [7:0] d, input logic two);
        send(1'b1, c);
        if (two)
            send(1'b0, d);
        @(posedge clk);
        cmd <= '{1'b0, 1'b0, ~cmd.value};
        repeat (3) @(posedge clk);
        #1;
    endtask : cmd1
    task automatic wait_run();
        int n = 0;
        while (core_rst !== 1'b0 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        #1;
        chk("core_rst", 16'(core_rst), 16'h0);
    endtask : wait_run
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            test_done();
        end
    end
    initial
    begin
        logic [6:0] a;
        logic [6:0] b;
        logic [7:0] d;
        logic       sc;
        repeat (7) @(posedge clk);
        #1;
        chk("in reset", 16'({osc_en, core_rst, ground_tie_enable}), 16'h3);
        @(posedge clk);
        rst <= 1'b0;
        wait_run();
        chk("latch", 16'(latch_array), 16'(INIT));
        chk("idle outs", 16'({osc_en, ground_tie_enable, driver_release, sync_release,
            conv_en}), 16'h18);
        sc = scan_clock_out;
        repeat (SCAN_DIV_DEF) @(posedge clk);
        #1;
        chk("scan", 16'(scan_clock_out), 16'(!sc));
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 8'h00 : 8'($random(seed));
            cmd1(CMD_GROUND_TIE, d, 1'b1);
            chk("tie", 16'(ground_tie_enable), 16'(d[0]));
        end
        $display("test tie done");
        for (int w = 0; w < 2; w++)
        begin
            cmd1(CMD_BOOST, 8'h01, 1'b1);
            cmd1(CMD_SLEEP, 8'h00, 1'b0);
            chk("sleep", 16'({sleep_active, osc_en, conv_en, analog_en}), 16'hC);
            chk("kept", 16'(ground_tie_enable), 16'(d[0]));
            cmd1(w ? CMD_DISPLAY : CMD_BOOST, 8'($random(seed)), 1'b1);
            chk("wake", 16'({sleep_active, analog_en}), 16'h1);
        end
        $display("test sleep done");
        cmd1(CMD_DISPLAY, 8'h01, 1'b1);
        chk("drive", 16'({driver_release, sync_release}), 16'h3);
        // Disturb the latches so the reload below has something to undo
        cmd1(CMD_BRIGHT_A, 8'h00, 1'b1);
        cmd1(CMD_SW_RESET, 8'h00, 1'b0);
        chk("swrst", 16'({core_rst, ground_tie_enable, osc_en, driver_release}), 16'hE);
        wait_run();
        chk("reload", 16'(latch_array), 16'(INIT));
        $display("test soft reset done");
        a = 7'($random(seed));
        b = 7'h7F;
        cmd1(CMD_BRIGHT_A, {1'b0, a}, 1'b1);
        cmd1(CMD_BRIGHT_B, {1'b0, b}, 1'b1);
        chk("bright", 16'(latch_array), cfg_of(a, b));
        cmd1(CMD_PROGRAMMED_FLAG_CHECK, 8'h00, 1'b0);
        chk("unsealed", 16'(core_rst), 16'h0);
        cmd1(CMD_GROUND_TIE, 8'h00, 1'b1);
        cmd1(CMD_OTP_BURN, 8'h00, 1'b1);
        chk("no burn", 16'(burn_busy), 16'h0);
        cmd1(CMD_OTP_BURN, 8'h01, 1'b1);
        cmd1(CMD_SW_RESET, 8'h00, 1'b0);
        chk("burn", 16'({burn_busy, core_rst}), 16'h2);
        repeat (BURN_N + 20) @(posedge clk);
        #1;
        chk("burn end", 16'(burn_busy), 16'h0);
        // Overwrite a latch so only a real reload from the fuses restores it
        cmd1(CMD_BRIGHT_A, {1'b0, ~a}, 1'b1);
        cmd1(CMD_SW_RESET, 8'h00, 1'b0);
        wait_run();
        chk("fused", 16'(latch_array), cfg_of(a, b));
        cmd1(CMD_DISPLAY, 8'h03, 1'b1);
        cmd1(CMD_PROGRAMMED_FLAG_CHECK, 8'h00, 1'b0);
        chk("sealed", 16'({core_rst, driver_release}), 16'h2);
        wait_run();
        $display("test burn done");
        // Converter on, so the pad check below can see it stop
        cmd1(CMD_BOOST, 8'h01, 1'b1);
        @(posedge clk);
        rst_pad_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("pad low", 16'({osc_en, core_rst, conv_en}), 16'h2);
        @(posedge clk);
        rst_pad_n <= 1'b1;
        wait_run();
        chk("pad high", 16'({osc_en, ground_tie_enable}), 16'h3);
        $display("test pad done");
        test_done();
    end
endmodule : otp_reset_sleep_control_tb_top
bind otprs_ctrl otprs_ctrl_sva #(.BURN_CYCLES(BURN_CYCLES)) u_sva (.clk, .rst, .rst_pad_n,
    .cmd, .programmed_flag, .antifuse_pwr_on, .antifuse_rd_en, .antifuse_burn_en, .core_rst,
    .osc_en, .conv_en, .analog_en, .driver_release, .ground_tie_enable, .sleep_active,
    .burn_busy);
